// ---- pkg/pvlfo_pkg.sv ----
/*
  constants, types and reset values for the two-channel low-frequency
  modulation oscillator; assumes a 25 MHz system clock and a tempo
  tick stream of 96 ticks per quarter note
*/
package pvlfo_pkg;
  localparam int     NUM_LFO   = 2;
  localparam int     NUM_VOICE = 4;
  localparam longint CLK_HZ    = 25_000_000;
  localparam longint TWO32     = 64'h1_0000_0000;
  // frequency end points in millihertz
  localparam longint RATE_MIN_MHZ = 41;
  localparam longint RATE_MAX_MHZ = 65_400;
  localparam longint MOD_CEIL_MHZ = 1_280_000;
  localparam logic [31:0] INC_MIN  = 32'((RATE_MIN_MHZ * TWO32) / (CLK_HZ * 1000));
  localparam logic [31:0] INC_MAX  = 32'((RATE_MAX_MHZ * TWO32) / (CLK_HZ * 1000));
  localparam logic [31:0] INC_CEIL = 32'((MOD_CEIL_MHZ * TWO32) / (CLK_HZ * 1000));
  localparam logic [31:0] RATE_QUAD = 32'((longint'(INC_MAX - INC_MIN) << 16) / (255 * 255));
  localparam logic [31:0] MOD_STEP  = (INC_CEIL - INC_MAX) / 32'd255;
  // tempo divisions, per-tick phase step at 96 ticks per quarter
  localparam logic [15:0] DIV_COUNT = 16'd20;
  localparam logic [31:0] DIV_INC [0:19] = '{
    32'(TWO32 / 1536), 32'(TWO32 / 1152), 32'(TWO32 / 768), 32'(TWO32 / 384),
    32'(TWO32 / 192),  32'(TWO32 / 144),  32'(TWO32 / 128), 32'(TWO32 / 96),
    32'(TWO32 / 72),   32'(TWO32 / 64),   32'(TWO32 / 48),  32'(TWO32 / 36),
    32'(TWO32 / 32),   32'(TWO32 / 24),   32'(TWO32 / 18),  32'(TWO32 / 16),
    32'(TWO32 / 12),   32'(TWO32 / 9),    32'(TWO32 / 8),   32'(TWO32 / 6)};
  // start delay: 640 chunks, 256 silent then 384 of fade
  localparam longint DELAY_MAX_MS  = 6_590;
  localparam longint DELAY_STEPS   = 255;
  localparam logic [9:0] DLY_CHUNKS = 10'd640;
  localparam logic [9:0] DLY_SILENT = 10'd256;
  localparam logic [17:0] DLY_UNIT_CYC =
    18'((DELAY_MAX_MS * (CLK_HZ / 1000)) / (DELAY_STEPS * 640));
  localparam logic [17:0] DLY_FADE_MUL = 18'(65536 / (640 - 256));
  localparam logic [8:0]  GAIN_FULL    = 9'h100;
  // external tempo considered absent after this long without a tick
  localparam longint EXT_TIMEOUT_MS  = 500;
  localparam int     EXT_TIMEOUT_CYC = int'(EXT_TIMEOUT_MS * (CLK_HZ / 1000));
  localparam logic [5:0]  SLEW_TICK_CYC = 6'd63;
  // phase offsets
  localparam logic [9:0]  DEG_FULL   = 10'd360;
  localparam logic [31:0] PH_PER_DEG = 32'(TWO32 / 360);
  localparam logic [7:0]  STEPPED_PHASE_OFFSET_MIN = 8'h01;
  localparam logic [7:0]  STEPPED_PHASE_OFFSET_MAX = 8'hfe;
  localparam logic [7:0]  MID_LEVEL  = 8'h80;

  typedef enum logic [2:0] {
    SHP_SINE  = 3'b000,
    SHP_TRI   = 3'b001,
    SHP_SQR   = 3'b010,
    SHP_RUP   = 3'b011,
    SHP_RDN   = 3'b100,
    SHP_RSTEP = 3'b101,
    SHP_RGLD  = 3'b110
  } pvlfo_shape_type;

  typedef enum logic [1:0] {
    PH_PER_VOICE = 2'b00,
    PH_SHARED    = 2'b01,
    PH_STEPPED   = 2'b10
  } pvlfo_phase_type;

  typedef struct packed {
    logic [7:0]      rate;
    logic [7:0]      rate_mod;
    logic [7:0]      delay;
    logic [7:0]      slew;
    logic [7:0]      stepped_phase_offset;
    pvlfo_shape_type shape;
    pvlfo_phase_type phase_mode;
    logic            key_sync;
    logic            tempo_sync_enable;
  } pvlfo_cfg_type;

  localparam pvlfo_cfg_type CFG_RESET = '{
    rate: 8'h00, rate_mod: 8'h00, delay: 8'h00, slew: 8'h00, stepped_phase_offset: 8'h01,
    shape: SHP_TRI, phase_mode: PH_PER_VOICE, key_sync: 1'b0,
    tempo_sync_enable: 1'b0};
endpackage : pvlfo_pkg

// ---- hdl/pvlfo_voice.sv ----
/*
  one voice of one oscillator: phase accumulator, shape generator,
  random levels, fade gain and slope limiter; expects increments,
  gain and offsets prepared by the parent
*/
`timescale 1ns/1ns
`default_nettype none
module pvlfo_voice
  import pvlfo_pkg::*;
#(
  parameter logic [31:0] START_PHASE = 32'h0000_0000,
  parameter logic [15:0] SEED        = 16'hace1
)(
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  // phase control
  input  wire logic [31:0]     inc,
  input  wire logic            restart,
  input  wire logic            use_shared,
  input  wire logic [31:0]     shared_acc,
  input  wire logic [31:0]     phase_ofs,
  // shaping
  input  wire pvlfo_shape_type shape,
  input  wire logic [8:0]      gain,
  input  wire logic [7:0]      slew,
  input  wire logic            slew_tick,
  // results
  output logic [31:0]          acc_out,
  output logic [7:0]           value_ff,
  output logic                 wrap_ff
);
  import pvlfo_pkg::*;

  logic [31:0] acc_ff;
  logic [31:0] eff_ph;
  logic [31:0] prev_ph_ff;
  logic [15:0] lfsr_ff;
  logic [7:0]  hold_ff;
  logic [7:0]  glide_ff;
  logic        wrap;
  logic        byte_step;
  logic [7:0]  p;
  logic [13:0] par;
  logic [7:0]  wave;
  logic signed [9:0]  dev;
  logic signed [19:0] scaled;
  logic [7:0]  target;
  logic [8:0]  step;

  // accumulator, restarted on a note strike when retrigger is on
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      acc_ff <= START_PHASE;
    else if (restart)
      acc_ff <= START_PHASE;
    else
      acc_ff <= acc_ff + inc;
  assign acc_out = acc_ff;

  // shared and stepped modes ride on voice one's accumulator
  assign eff_ph    = (use_shared ? shared_acc : acc_ff) + phase_ofs;
  assign wrap      = prev_ph_ff[31] && !eff_ph[31];
  assign byte_step = prev_ph_ff[31:24] != eff_ph[31:24];

  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      prev_ph_ff <= 32'h0000_0000;
      wrap_ff    <= 1'b0;
    end
    else
    begin
      prev_ph_ff <= eff_ph;
      wrap_ff    <= wrap;
    end

  // random levels: free-running lfsr sampled at period boundary
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      lfsr_ff <= SEED;
      hold_ff <= MID_LEVEL;
    end
    else
    begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      if (wrap)
        hold_ff <= lfsr_ff[7:0];
    end

  // glide walks one level per phase byte, so a full swing fits a period
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      glide_ff <= MID_LEVEL;
    else if (byte_step && glide_ff < hold_ff)
      glide_ff <= glide_ff + 8'h01;
    else if (byte_step && glide_ff > hold_ff)
      glide_ff <= glide_ff - 8'h01;

  // shape table; sine is a parabola pair, close enough for modulation
  assign p   = eff_ph[31:24];
  assign par = 14'({7'h00, p[6:0]} * {7'h00, 7'h7f - p[6:0]});
  always_comb
  begin
    case (shape)
      SHP_SINE:  wave = p[7] ? MID_LEVEL - 8'(par >> 5) : MID_LEVEL + 8'(par >> 5);
      SHP_TRI:   wave = p[7] ? ~{p[6:0], 1'b0} : {p[6:0], 1'b0};
      SHP_SQR:   wave = p[7] ? 8'h00 : 8'hff;
      SHP_RUP:   wave = p;
      SHP_RDN:   wave = ~p;
      SHP_RSTEP: wave = hold_ff;
      SHP_RGLD:  wave = glide_ff;
      default:   wave = MID_LEVEL;
    endcase
  end

  // fade gain scales the swing about mid level
  assign dev    = 10'(signed'({2'b00, wave}) - signed'({2'b00, MID_LEVEL}));
  // widen both factors first; a 10-bit product would wrap at full gain
  assign scaled = (20'(dev) * 20'(signed'({1'b0, gain}))) >>> 8;
  assign target = 8'(10'(scaled) + 10'(MID_LEVEL));
  assign step   = 9'h100 - 9'(slew);

  // slope limiter; setting 0 bypasses, 255 moves one level per tick
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      value_ff <= MID_LEVEL;
    else if (slew == 8'h00)
      value_ff <= target;
    else if (slew_tick && target > value_ff)
      value_ff <= (9'(target - value_ff) > step) ? 8'(value_ff + step) : target;
    else if (slew_tick && target < value_ff)
      value_ff <= (9'(value_ff - target) > step) ? 8'(value_ff - step) : target;
endmodule : pvlfo_voice
`default_nettype wire

// ---- hdl/pvlfo_top.sv ----
/*
  two-channel low-frequency modulation oscillator with per-voice
  outputs, tempo lock, start delay with fade, retrigger and phase
  modes; settings arrive as plain ports, tempo ticks and note strikes
  are one-cycle pulses synchronous to clk_sys
*/
`timescale 1ns/1ns
`default_nettype none
module pvlfo_top
  import pvlfo_pkg::*;
#(
  parameter int EXT_TIMEOUT = EXT_TIMEOUT_CYC
)(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  // settings, one set per oscillator
  input  wire pvlfo_cfg_type           cfg_in      [NUM_LFO],
  // note strikes, one pulse per oscillator
  input  wire logic [NUM_LFO-1:0]      note_strike,
  // master tempo clock, 96 ticks per quarter
  input  wire logic                    int_tempo_tick,
  input  wire logic                    ext_tempo_tick,
  input  wire logic                    ext_clock_select,
  // modulation router and envelope outputs
  output logic [7:0]                   lfo_value   [NUM_LFO][NUM_VOICE],
  output logic [NUM_LFO-1:0]           env_trigger,
  // shape indicators, one-hot per oscillator
  output logic [6:0]                   shape_led   [NUM_LFO],
  output logic                         ext_tempo_active
);
  import pvlfo_pkg::*;

  logic [31:0] ext_idle_ff;
  logic        ext_live_ff;
  logic        tempo_tick;
  logic [5:0]  slew_cnt_ff;
  logic        slew_tick;

  // external tempo presence, timing out to the internal source
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      ext_idle_ff <= 32'h0000_0000;
      ext_live_ff <= 1'b0;
    end
    else if (ext_tempo_tick)
    begin
      ext_idle_ff <= 32'h0000_0000;
      ext_live_ff <= 1'b1;
    end
    else if (ext_idle_ff >= 32'(EXT_TIMEOUT))
      ext_live_ff <= 1'b0;
    else
      ext_idle_ff <= ext_idle_ff + 32'h0000_0001;

  // select the live tempo reference
  assign tempo_tick = (ext_clock_select && ext_live_ff) ? ext_tempo_tick
                                                        : int_tempo_tick;
  assign ext_tempo_active = ext_clock_select && ext_live_ff;

  // common tick pacing every slope limiter
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      slew_cnt_ff <= 6'h00;
    else if (slew_cnt_ff == SLEW_TICK_CYC)
      slew_cnt_ff <= 6'h00;
    else
      slew_cnt_ff <= slew_cnt_ff + 6'h01;
  assign slew_tick = slew_cnt_ff == SLEW_TICK_CYC;

  // one full channel per oscillator, nothing shared but tempo and the slope tick
  for (genvar l = 0; l < NUM_LFO; l++)
  begin : g_lfo
    pvlfo_cfg_type cfg_ff;
    logic [31:0]   sq;
    logic [31:0]   base_inc;
    logic [31:0]   mod_inc;
    logic [31:0]   free_inc;
    logic [4:0]    div_idx;
    logic [31:0]   run_inc;
    logic          restart;
    logic [17:0]   unit_len;
    logic [17:0]   unit_ff;
    logic [9:0]    chunk_ff;
    logic [17:0]   fade_prod;
    logic [8:0]    nxt_gain;
    logic [8:0]    gain_ff;
    logic [7:0]    stepped_phase_offset;
    logic [31:0]   ofs_ff      [NUM_VOICE];
    logic [31:0]   acc         [NUM_VOICE];
    logic [NUM_VOICE-1:0] wrap;
    logic [6:0]    led_ff;

    // settings take their defaults at reset, then follow the ports
    always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
        cfg_ff <= CFG_RESET;
      else
        cfg_ff <= cfg_in[l];

    // squared rate keeps the curve monotonic and slow at the bottom
    assign sq       = 32'(cfg_ff.rate) * 32'(cfg_ff.rate);
    assign base_inc = INC_MIN + 32'((64'(sq) * 64'(RATE_QUAD)) >> 16);
    assign mod_inc  = base_inc + 32'(cfg_ff.rate_mod) * MOD_STEP;
    assign free_inc = (mod_inc > INC_CEIL) ? INC_CEIL : mod_inc;

    // in tempo mode the rate picks a division, stepped per tempo tick
    assign div_idx = 5'((16'(cfg_ff.rate) * DIV_COUNT) >> 8);
    always_comb
    begin
      if (cfg_ff.tempo_sync_enable)
        run_inc = tempo_tick ? DIV_INC[div_idx] : 32'h0000_0000;
      else
        run_inc = free_inc;
    end

    // strikes only count with retrigger on
    assign restart = note_strike[l] && cfg_ff.key_sync;

    // start timer: chunks of a length set by the delay setting
    assign unit_len = 18'(cfg_ff.delay) * DLY_UNIT_CYC;
    always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
      begin
        unit_ff  <= 18'h00000;
        chunk_ff <= 10'h000;
      end
      else if (restart)
      begin
        unit_ff  <= 18'h00000;
        chunk_ff <= 10'h000;
      end
      else if (chunk_ff != DLY_CHUNKS)
      begin
        if (unit_ff + 18'h00001 >= unit_len)
        begin
          unit_ff  <= 18'h00000;
          chunk_ff <= chunk_ff + 10'h001;
        end
        else
          unit_ff <= unit_ff + 18'h00001;
      end

    // silent for the first 40% of chunks, then a linear fade
    assign fade_prod = 18'(chunk_ff - DLY_SILENT) * DLY_FADE_MUL;
    always_comb
    begin
      if (cfg_ff.delay == 8'h00 || chunk_ff == DLY_CHUNKS)
        nxt_gain = GAIN_FULL;
      else if (chunk_ff < DLY_SILENT)
        nxt_gain = 9'h000;
      else
        nxt_gain = 9'(fade_prod >> 8);
    end

    always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
        gain_ff <= 9'h000;
      else
        gain_ff <= nxt_gain;

    // out-of-range offset settings are pulled into 1..254
    assign stepped_phase_offset = (cfg_ff.stepped_phase_offset < STEPPED_PHASE_OFFSET_MIN) ? STEPPED_PHASE_OFFSET_MIN :
                    (cfg_ff.stepped_phase_offset > STEPPED_PHASE_OFFSET_MAX) ? STEPPED_PHASE_OFFSET_MAX : cfg_ff.stepped_phase_offset;

    for (genvar v = 0; v < NUM_VOICE; v++)
    begin : g_voice
      logic [9:0] deg_raw;
      logic [9:0] deg_a;
      logic [9:0] deg;

      // voice n sits n steps on; max product is below three turns
      assign deg_raw = 10'(v) * 10'(stepped_phase_offset);
      assign deg_a   = (deg_raw >= DEG_FULL) ? deg_raw - DEG_FULL : deg_raw;
      assign deg     = (deg_a >= DEG_FULL) ? deg_a - DEG_FULL : deg_a;

      // registered offset; only the stepped mode applies one
      always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
          ofs_ff[v] <= 32'h0000_0000;
        else if (cfg_ff.phase_mode == PH_STEPPED)
          ofs_ff[v] <= 32'(deg) * PH_PER_DEG;
        else
          ofs_ff[v] <= 32'h0000_0000;

      // per-voice start phases step by 32'h3c6e_f372 per voice so voices stay unrelated
      pvlfo_voice #(
        .START_PHASE (32'(v) * 32'h3c6e_f372),
        .SEED        (16'hace1 ^ 16'(v * 4919 + l * 211))
      ) u_voice (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .inc        (run_inc),
        .restart    (restart),
        .use_shared (cfg_ff.phase_mode != PH_PER_VOICE),
        .shared_acc (acc[0]),
        .phase_ofs  (ofs_ff[v]),
        .shape      (cfg_ff.shape),
        .gain       (gain_ff),
        .slew       (cfg_ff.slew),
        .slew_tick  (slew_tick),
        .acc_out    (acc[v]),
        .value_ff   (lfo_value[l][v]),
        .wrap_ff    (wrap[v])
      );
    end

    // voice one's period boundary doubles as an envelope trigger
    assign env_trigger[l] = wrap[0];

    // exactly one indicator follows the selected shape
    always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
        led_ff <= 7'h02;
      else
        led_ff <= 7'(7'h01 << cfg_ff.shape);
    assign shape_led[l] = led_ff;
  end
endmodule : pvlfo_top
`default_nettype wire

// ---- testbench/pvlfo_tempo_src.sv ----
/*
  tempo clock source model: internal and external tick streams;
  assumes the bench sets the tick spacing before release of reset
*/
`timescale 1ns/1ns
`default_nettype none
module pvlfo_tempo_src (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // tick spacing in cycles and external source on or off
  input  wire logic [15:0] int_gap,
  input  wire logic [15:0] ext_gap,
  input  wire logic        ext_run,
  // tick pulses toward the oscillator
  output logic             int_tempo_tick,
  output logic             ext_tempo_tick
);
  logic [15:0] int_cnt_ff;
  logic [15:0] ext_cnt_ff;

  // internal ticks run for ever, one cycle wide
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      int_cnt_ff     <= 16'h0001;
      int_tempo_tick <= 1'b0;
    end
    else
    begin
      int_tempo_tick <= (int_cnt_ff == int_gap);
      int_cnt_ff     <= (int_cnt_ff == int_gap) ? 16'h0001 : int_cnt_ff + 16'h0001;
    end

  // external ticks stop dead when unplugged, so fallback can be seen
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      ext_cnt_ff     <= 16'h0001;
      ext_tempo_tick <= 1'b0;
    end
    else if (!ext_run)
    begin
      ext_cnt_ff     <= 16'h0001;
      ext_tempo_tick <= 1'b0;
    end
    else
    begin
      ext_tempo_tick <= (ext_cnt_ff == ext_gap);
      ext_cnt_ff     <= (ext_cnt_ff == ext_gap) ? 16'h0001 : ext_cnt_ff + 16'h0001;
    end
endmodule : pvlfo_tempo_src
`default_nettype wire

// ---- testbench/pvlfo_chk_sva.sv ----
/*
  port checker for pvlfo_top, bound to every instance below;
  assumes settings are plain levels and ticks one-cycle pulses
*/
`timescale 1ns/1ns
`default_nettype none
module pvlfo_chk
  import pvlfo_pkg::*;
#(
  parameter int EXT_TIMEOUT = 200
)(
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               resetn,
  // inputs of the block
  input wire pvlfo_cfg_type      cfg_in [NUM_LFO],
  input wire logic [NUM_LFO-1:0] note_strike,
  input wire logic               int_tempo_tick,
  input wire logic               ext_tempo_tick,
  input wire logic               ext_clock_select,
  // outputs of the block
  input wire logic [7:0]         lfo_value [NUM_LFO][NUM_VOICE],
  input wire logic [NUM_LFO-1:0] env_trigger,
  input wire logic [6:0]         shape_led [NUM_LFO],
  input wire logic               ext_tempo_active
);
  logic [1:0] age_ff;
  logic [3:0] calm_ff;
  int         gap_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // edges since release, cycles since external tick, quiet time on lfo 1
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      age_ff  <= 2'd0;
      gap_ff  <= EXT_TIMEOUT + 8;
      calm_ff <= 4'h0;
    end
    else
    begin
      age_ff  <= (age_ff == 2'd3) ? age_ff : age_ff + 2'd1;
      gap_ff  <= ext_tempo_tick ? 0 : (gap_ff > EXT_TIMEOUT + 7) ? gap_ff : gap_ff + 1;
      calm_ff <= (int_tempo_tick || ext_tempo_tick || note_strike[1] ||
                  !$stable(cfg_in[1])) ? 4'h0 : (calm_ff == 4'hf) ? calm_ff : calm_ff + 4'h1;
    end

  sequence strike_s;
    note_strike[0] && cfg_in[0].key_sync && cfg_in[0].delay != 8'h00 &&
      cfg_in[0].slew == 8'h00 && $stable(cfg_in[0]);
  endsequence
  sequence shared_s;
    (cfg_in[0].phase_mode == PH_SHARED && cfg_in[0].shape == SHP_TRI &&
      cfg_in[0].slew == 8'h00 && $stable(cfg_in[0])) [*5];
  endsequence

  rst_vals_a: assert property (age_ff == 2'd0 |->
    shape_led[1] == 7'h02 && lfo_value[1][2] == 8'h80 && !env_trigger[1])
    else $error("values after release wrong");
  led_match0_a: assert property (age_ff >= 2'd2 |->
    shape_led[0] == 7'h01 << $past(cfg_in[0].shape, 2))
    else $error("lfo 0 indicator wrong");
  led_match1_a: assert property (age_ff >= 2'd2 |->
    shape_led[1] == 7'h01 << $past(cfg_in[1].shape, 2))
    else $error("lfo 1 indicator wrong");
  env_pulse_a: assert property (env_trigger[0] |=> !env_trigger[0])
    else $error("envelope trigger too long");
  ext_live_a: assert property (ext_tempo_tick ##1 ext_clock_select [*2] |->
    ext_tempo_active)
    else $error("external tempo not taken");
  ext_expire_a: assert property (gap_ff > EXT_TIMEOUT + 2 |-> !ext_tempo_active)
    else $error("external tempo not dropped");
  retrig_mute_a: assert property (strike_s ##1 $stable(cfg_in[0]) [*4] |->
    lfo_value[0][0] == 8'h80 && lfo_value[0][3] == 8'h80)
    else $error("lfo 0 not silent after strike");
  shared_same_a: assert property (shared_s |->
    lfo_value[0][3] == lfo_value[0][0])
    else $error("shared voices differ");
  sync_hold_a: assert property (calm_ff >= 4'h6 && cfg_in[1].tempo_sync_enable &&
    cfg_in[1].slew == 8'h00 && cfg_in[1].delay == 8'h00 |-> $stable(lfo_value[1][1]))
    else $error("synced lfo moved without tick");
  slew_limit_a: assert property (
    (cfg_in[1].slew == 8'hff && $stable(cfg_in[1])) [*3] |->
    8'(lfo_value[1][0] - $past(lfo_value[1][0]) + 8'h01) <= 8'h02)
    else $error("lfo 1 slope too steep");
endmodule : pvlfo_chk

bind pvlfo_top pvlfo_chk #(.EXT_TIMEOUT(EXT_TIMEOUT)) u_chk (.clk_sys, .resetn,
  .cfg_in, .note_strike, .int_tempo_tick, .ext_tempo_tick, .ext_clock_select,
  .lfo_value, .env_trigger, .shape_led, .ext_tempo_active);
`default_nettype wire

// ---- testbench/test_per_voice_lfo_generator.sv ----
/*
  self-checking bench for pvlfo_top with the tempo source model;
  inputs move 1 ns after each rising edge of a 25 MHz clock
*/
`timescale 1ns/1ns
`default_nettype none
module test_per_voice_lfo_generator;
  import pvlfo_pkg::*;
  localparam int TMO = 200;
  logic               clk_sys = 1'b0;
  logic               resetn;
  pvlfo_cfg_type      cfg_in [NUM_LFO];
  logic [NUM_LFO-1:0] note_strike;
  logic               int_tempo_tick;
  logic               ext_tempo_tick;
  logic               ext_clock_select;
  logic [7:0]         lfo_value [NUM_LFO][NUM_VOICE];
  logic [NUM_LFO-1:0] env_trigger;
  logic [6:0]         shape_led [NUM_LFO];
  logic               ext_tempo_active;
  logic [15:0]        int_gap;
  logic [15:0]        ext_gap;
  logic               ext_run;
  int                 err_count = 0;
  int                 checked = 0;
  int                 cyc = 0;
  int                 a;
  int                 b;
  int                 s;
  longint             inc;

  pvlfo_top #(.EXT_TIMEOUT(TMO)) dut (.clk_sys, .resetn, .cfg_in, .note_strike,
    .int_tempo_tick, .ext_tempo_tick, .ext_clock_select, .lfo_value, .env_trigger,
    .shape_led, .ext_tempo_active);
  pvlfo_tempo_src u_tempo (.clk_sys, .resetn, .int_gap, .ext_gap, .ext_run,
    .int_tempo_tick, .ext_tempo_tick);

  // 40 ns clock and a running cycle count for period measurements
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait for the next envelope trigger of one lfo
  task automatic wait_trig(input int l, output int t);
    int n;
    n = 0;
    while (env_trigger[l] !== 1'b1 && n < 30000)
    begin
      step(1);
      n++;
    end
    if (n == 30000)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
    t = cyc;
    step(1);
  endtask : wait_trig

  task automatic strike(input int l);
    note_strike[l] = 1'b1;
    step(1);
    note_strike[l] = 1'b0;
  endtask : strike

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // watchdog well beyond the longest expected run
  initial
  begin
    #(90000 * 40);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    resetn = 1'b0;
    cfg_in[0] = CFG_RESET;
    cfg_in[1] = CFG_RESET;
    note_strike = '0;
    ext_clock_select = 1'b0;
    int_gap = 16'd50;
    ext_gap = 16'd40;
    ext_run = 1'b0;
    step(11);
    chk(shape_led[0], 32'h02);
    chk(lfo_value[1][3], 32'h80);
    chk(ext_tempo_active, 32'h0);
    step(1);
    resetn = 1'b1;
    $display("test reset done");
    // every shape, the two lfos in opposite order
    for (int i = 0; i < 7; i++)
    begin
      cfg_in[0].shape = pvlfo_shape_type'(i);
      cfg_in[1].shape = pvlfo_shape_type'(6 - i);
      step(4);
      chk(shape_led[0], 32'h1 << i);
      chk(shape_led[1], 32'h1 << (6 - i));
    end
    $display("test shapes done");
    // fastest free run, router lift lands just below the ceiling
    cfg_in[0].rate = 8'hff;
    cfg_in[0].rate_mod = 8'hff;
    inc = 7 + ((longint'(65025) * RATE_QUAD) >> 16) + 255 * longint'(MOD_STEP);
    if (inc > INC_CEIL)
      inc = INC_CEIL;
    wait_trig(0, a);
    wait_trig(0, b);
    chk(32'(b - a == TWO32 / inc || b - a == TWO32 / inc + 1), 32'h1);
    $display("test ceiling done");
    // tempo lock: division picks ticks per period
    cfg_in[1].tempo_sync_enable = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      cfg_in[1].rate = (i == 0) ? 8'd231 : 8'd192;
      step(4);
      wait_trig(1, a);
      wait_trig(1, b);
      chk(b - a, (i == 0) ? 32'd400 : 32'd800);
    end
    ext_run = 1'b1;
    ext_clock_select = 1'b1;
    step(60);
    chk(ext_tempo_active, 32'h1);
    wait_trig(1, a);
    wait_trig(1, b);
    chk(b - a, 32'd640);
    ext_run = 1'b0;
    step(TMO + 10);
    chk(ext_tempo_active, 32'h0);
    wait_trig(1, a);
    wait_trig(1, b);
    chk(b - a, 32'd800);
    $display("test tempo done");
    // strikes ignored, then restarting the period
    cfg_in[1].rate = 8'd231;
    step(4);
    wait_trig(1, a);
    step(200);
    strike(1);
    wait_trig(1, b);
    chk(b - a, 32'd400);
    cfg_in[1].key_sync = 1'b1;
    step(4);
    wait_trig(1, a);
    // strike in the first half, so the restart itself is no boundary
    step(120);
    strike(1);
    s = cyc;
    wait_trig(1, b);
    chk(32'(b - s >= 345 && b - s <= 410), 32'h1);
    $display("test retrigger done");
    // slope limiter on lfo 1: frozen ramp flipped to its mirror
    cfg_in[1].tempo_sync_enable = 1'b0;
    cfg_in[1].rate = 8'h00;
    cfg_in[1].shape = SHP_RUP;
    step(6);
    a = lfo_value[1][0];
    cfg_in[1].slew = 8'hff;
    cfg_in[1].shape = SHP_RDN;
    step(640);
    b = lfo_value[1][0];
    chk(32'(b != a && b - a <= 11 && a - b <= 11), 32'h1);
    $display("test slew done");
    // shared then stepped phase on lfo 0
    cfg_in[0].shape = SHP_TRI;
    cfg_in[0].phase_mode = PH_SHARED;
    step(10);
    chk(lfo_value[0][3], lfo_value[0][0]);
    cfg_in[0].shape = SHP_SQR;
    cfg_in[0].phase_mode = PH_STEPPED;
    cfg_in[0].stepped_phase_offset = 8'd90;
    step(3000);
    chk(32'((lfo_value[0][0] >= 8'h80) != (lfo_value[0][2] >= 8'h80)), 32'h1);
    chk(32'((lfo_value[0][1] >= 8'h80) != (lfo_value[0][3] >= 8'h80)), 32'h1);
    $display("test phase done");
    // start delay: a strike silences every voice of lfo 0
    cfg_in[0].delay = 8'h01;
    cfg_in[0].key_sync = 1'b1;
    step(4);
    strike(0);
    step(6);
    for (int v = 0; v < NUM_VOICE; v++)
      chk(lfo_value[0][v], 32'h80);
    step(1000);
    chk(lfo_value[0][2], 32'h80);
    $display("test delay done");
    tally_and_finish();
  end
endmodule : test_per_voice_lfo_generator
`default_nettype wire
